// [xfer_pkg.sv]
// Constants, encodings and carrier types for the transfer count and host address register group.
// Assumes an eight bit local processor port and one 200 MHz system clock.
//
// Functional notes
// - Transfer count survives firmware and hard reset.
// - Resets clear FIFO, host and partial counters.
// - View zero: 18h-1Ah hold count bytes.
// - FIFO writes decrement count; count gates requests.
// - View one: FIFO, host, partial counters; bit7 forces full.
// - Diagnostic counters load on write, read back live.
// - Address survives resets; FIFO pointers are cleared.
// - View zero: 1Bh-1Eh hold address bytes.
// - Top byte is address or preempt counter.
// - Address advances 0, 1, 2 or 4 per access.
// - View one: 1Bh/1Ch expose writable FIFO pointers.
// - Data buffer at 1Fh survives resets.
// - Host pin functions follow selected bus type.
package xfer_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam int MPU_ADDR_W = 5;
    localparam logic [4:0] OFF_COUNT_LOW = 5'h18;
    localparam logic [4:0] OFF_COUNT_MID = 5'h19;
    localparam logic [4:0] OFF_COUNT_HIGH = 5'h1a;
    localparam logic [4:0] OFF_ADDR_BYTE0 = 5'h1b;
    localparam logic [4:0] OFF_ADDR_BYTE1 = 5'h1c;
    localparam logic [4:0] OFF_ADDR_BYTE2 = 5'h1d;
    localparam logic [4:0] OFF_ADDR_BYTE3 = 5'h1e;
    localparam logic [4:0] OFF_BUFFER = 5'h1f;

    // ****************************************************************
    // Widths and field positions
    // ****************************************************************
    localparam int DATA_W = 8;
    localparam int COUNT_W = 24;
    localparam int ADDR_W = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_PTR_W = 7;
    localparam int FIFO_CNT_W = 8;
    localparam int HOST_CNT_W = 7;
    localparam int PART_CNT_W = 2;
    localparam int FORCE_FULL_BIT = 7;
    localparam int LOW_ADDR_W = 24;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [1:0] BUS_WIDE_ADDR = 2'h3;
    localparam logic [1:0] SIZE_NONE = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_HALF = 2'h2;
    localparam logic [31:0] INC_NONE = 32'h0000_0000;
    localparam logic [31:0] INC_BYTE = 32'h0000_0001;
    localparam logic [31:0] INC_HALF = 32'h0000_0002;
    localparam logic [31:0] INC_WORD = 32'h0000_0004;

    typedef enum logic [1:0] {ST_IDLE, ST_REQUEST, ST_RELEASE} engine_state_t;

    typedef struct packed {
        logic [4:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mpu_req_t;

endpackage

// [xfer_sync3.sv]
// Three stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs; the filtered level follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module xfer_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Pin side
    input wire logic [W-1:0] pin_in,
    // Filtered level
    output logic [W-1:0] level_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_level;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level_out <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level_out <= next_level;
        end
    end
endmodule
`default_nettype wire

// [xfer_fifo.sv]
// Data FIFO with loadable write and read pointers for diagnostics.
// Assumes pointers wider than the index so that full and empty are told apart.
`timescale 1ns/1ps
`default_nettype none
module xfer_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int PTR_W = 7
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    // Pointer access
    input wire logic wr_load_in,
    input wire logic rd_load_in,
    input wire logic [PTR_W-1:0] load_ptr_in,
    output logic [PTR_W-1:0] wr_ptr_out,
    output logic [PTR_W-1:0] rd_ptr_out
);
    localparam int IDX_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] next_wr;
    logic [PTR_W-1:0] next_rd;
    logic [PTR_W-1:0] fill;
    logic push;
    logic pop;

    // Diagnostic loads may set pointers that claim more than DEPTH entries; full then holds.
    assign fill = wr_ptr_out - rd_ptr_out;
    assign in_ready_out = (fill < DEPTH_P);
    assign out_valid_out = (fill != '0);
    assign out_data_out = mem[rd_ptr_out[IDX_W-1:0]];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        next_wr = wr_ptr_out;
        next_rd = rd_ptr_out;
        if (clear_in) begin
            next_wr = '0;
            next_rd = '0;
        end else begin
            if (wr_load_in) begin
                next_wr = load_ptr_in;
            end else if (push) begin
                next_wr = wr_ptr_out + 1'b1;
            end
            if (rd_load_in) begin
                next_rd = load_ptr_in;
            end else if (pop) begin
                next_rd = rd_ptr_out + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_out <= '0;
            rd_ptr_out <= '0;
        end else begin
            wr_ptr_out <= next_wr;
            rd_ptr_out <= next_rd;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (push && !clear_in && !wr_load_in) begin
            mem[wr_ptr_out[IDX_W-1:0]] <= in_data_in;
        end
    end
endmodule
`default_nettype wire

// [xfer_regs.sv]
// Transfer count, host address and data buffer register group with a host fill engine.
// Assumes the view select and bus type come from configuration logic on the same clock,
// and that host data and size stay stable while the acknowledge pin is asserted.
`timescale 1ns/1ps
`default_nettype none
module xfer_regs #(
    parameter int FIFO_DEPTH = xfer_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic fw_reset_in,
    // Configuration
    input wire logic view_sel_in,
    input wire logic [1:0] bus_type_in,
    // Processor port
    input wire xfer_pkg::mpu_req_t mpu_req_in,
    output logic [xfer_pkg::DATA_W-1:0] mpu_rdata_out,
    output logic fifo_rdy_out,
    // Host side
    input wire logic host_ack_pin_in,
    input wire logic preempt_pin_in,
    input wire logic [1:0] host_size_in,
    input wire logic [xfer_pkg::DATA_W-1:0] host_data_in,
    output logic host_req_out,
    output logic host_own_out,
    output logic [xfer_pkg::ADDR_W-1:0] host_addr_out,
    output logic [7:0] preempt_count_out
);
    import xfer_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    engine_state_t state;
    engine_state_t next_state;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [FIFO_CNT_W-1:0] fifo_cnt;
    logic [FIFO_CNT_W-1:0] next_fifo_cnt;
    logic [HOST_CNT_W-1:0] host_cnt;
    logic [HOST_CNT_W-1:0] next_host_cnt;
    logic [PART_CNT_W-1:0] part_cnt;
    logic [PART_CNT_W-1:0] next_part_cnt;
    logic [DATA_W-1:0] buf_data;
    logic [DATA_W-1:0] next_buf_data;
    logic buf_full;
    logic next_buf_full;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0] pins_level;
    logic ack_lvl;
    logic preempt_lvl;
    logic preempt_prev;
    logic preempt_tick;
    logic beat;
    logic push;
    logic pop;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic [FIFO_PTR_W-1:0] wr_ptr;
    logic [FIFO_PTR_W-1:0] rd_ptr;
    logic wr_at;
    logic cnt_wr;
    logic addr_wr;
    logic wr_ptr_load;
    logic rd_ptr_load;
    logic buf_load;
    logic buf_rd;
    logic wide_bus;
    logic [ADDR_W-1:0] inc;

    // ****************************************************************
    // Pin synchronisation and decode
    // ****************************************************************
    xfer_sync3 #(.W(2)) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in({preempt_pin_in, host_ack_pin_in}),
        .level_out(pins_level)
    );

    assign ack_lvl = pins_level[0];
    assign preempt_lvl = pins_level[1];
    assign preempt_tick = preempt_lvl && !preempt_prev;
    assign wide_bus = (bus_type_in == BUS_WIDE_ADDR);
    assign wr_at = mpu_req_in.wr;
    assign cnt_wr = wr_at && !view_sel_in && (mpu_req_in.addr >= OFF_COUNT_LOW) && (mpu_req_in.addr <= OFF_COUNT_HIGH);
    assign addr_wr = wr_at && (mpu_req_in.addr >= OFF_ADDR_BYTE0) && (mpu_req_in.addr <= OFF_ADDR_BYTE3)
        && !(view_sel_in && (mpu_req_in.addr <= OFF_ADDR_BYTE1));
    assign wr_ptr_load = wr_at && view_sel_in && (mpu_req_in.addr == OFF_ADDR_BYTE0);
    assign rd_ptr_load = wr_at && view_sel_in && (mpu_req_in.addr == OFF_ADDR_BYTE1);
    assign buf_rd = mpu_req_in.rd && (mpu_req_in.addr == OFF_BUFFER);

    always_comb begin
        case (host_size_in)
            SIZE_NONE: inc = INC_NONE;
            SIZE_BYTE: inc = INC_BYTE;
            SIZE_HALF: inc = INC_HALF;
            default: inc = INC_WORD;
        endcase
    end

    // ****************************************************************
    // Host fill engine
    // ****************************************************************
    // Bit 7 of the FIFO byte counter blocks filling as if the FIFO were full.
    assign push = beat && fifo_in_ready && !fifo_cnt[FORCE_FULL_BIT];
    assign host_req_out = (state == ST_REQUEST);
    // Three of the four buses carry ownership active low.
    assign host_own_out = wide_bus ? (state != ST_IDLE) : (state == ST_IDLE);

    always_comb begin
        next_state = state;
        beat = 1'b0;
        case (state)
            ST_IDLE: begin
                if (count != '0 && fifo_in_ready && !fifo_cnt[FORCE_FULL_BIT]) begin
                    next_state = ST_REQUEST;
                end
            end
            ST_REQUEST: begin
                if (ack_lvl) begin
                    beat = 1'b1;
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (!ack_lvl) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (fw_reset_in) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            preempt_prev <= 1'b0;
        end else begin
            state <= next_state;
            preempt_prev <= preempt_lvl;
        end
    end

    // ****************************************************************
    // Count, address and buffer: kept through every reset
    // ****************************************************************
    always_comb begin
        next_count = count;
        next_addr = addr;
        next_buf_data = buf_data;
        if (push) begin
            next_count = count - 24'h1;
        end
        if (beat) begin
            if (wide_bus) begin
                next_addr = addr + inc;
            end else begin
                next_addr[LOW_ADDR_W-1:0] = addr[LOW_ADDR_W-1:0] + inc[LOW_ADDR_W-1:0];
            end
        end
        if (!wide_bus && preempt_tick) begin
            next_addr[ADDR_W-1:LOW_ADDR_W] = addr[ADDR_W-1:LOW_ADDR_W] + 8'h01;
        end
        if (cnt_wr) begin
            case (mpu_req_in.addr)
                OFF_COUNT_LOW: next_count[7:0] = mpu_req_in.wdata;
                OFF_COUNT_MID: next_count[15:8] = mpu_req_in.wdata;
                default: next_count[23:16] = mpu_req_in.wdata;
            endcase
        end
        if (addr_wr) begin
            case (mpu_req_in.addr)
                OFF_ADDR_BYTE0: next_addr[7:0] = mpu_req_in.wdata;
                OFF_ADDR_BYTE1: next_addr[15:8] = mpu_req_in.wdata;
                OFF_ADDR_BYTE2: next_addr[23:16] = mpu_req_in.wdata;
                default: next_addr[31:24] = mpu_req_in.wdata;
            endcase
        end
        if (buf_load) begin
            next_buf_data = fifo_out_data;
        end
        if (wr_at && mpu_req_in.addr == OFF_BUFFER) begin
            next_buf_data = mpu_req_in.wdata;
        end
    end

    // No reset branch on purpose: these values must outlive both reset kinds.
    always_ff @(posedge sys_clk_in) begin
        count <= next_count;
        addr <= next_addr;
        buf_data <= next_buf_data;
    end

    assign host_addr_out = wide_bus ? addr : {8'h00, addr[LOW_ADDR_W-1:0]};
    assign preempt_count_out = wide_bus ? 8'h00 : addr[ADDR_W-1:LOW_ADDR_W];

    // ****************************************************************
    // Diagnostic counters, buffer flag and read data
    // ****************************************************************
    // A firmware reset empties the FIFO, so no byte may move into the buffer in that cycle.
    assign buf_load = !buf_full && fifo_out_valid && !fw_reset_in;
    assign pop = buf_load;
    assign fifo_rdy_out = buf_full;

    always_comb begin
        next_fifo_cnt = fifo_cnt + FIFO_CNT_W'(push) - FIFO_CNT_W'(pop);
        next_host_cnt = host_cnt + HOST_CNT_W'(beat);
        next_part_cnt = beat ? part_cnt + inc[PART_CNT_W-1:0] : part_cnt;
        next_buf_full = buf_load || (buf_full && !buf_rd);
        if (wr_at && view_sel_in) begin
            case (mpu_req_in.addr)
                OFF_COUNT_LOW: next_fifo_cnt = mpu_req_in.wdata;
                OFF_COUNT_MID: next_host_cnt = mpu_req_in.wdata[HOST_CNT_W-1:0];
                OFF_COUNT_HIGH: next_part_cnt = mpu_req_in.wdata[PART_CNT_W-1:0];
                default: ;
            endcase
        end
        if (fw_reset_in) begin
            next_fifo_cnt = '0;
            next_host_cnt = '0;
            next_part_cnt = '0;
            next_buf_full = 1'b0;
        end
        next_rdata = mpu_rdata_out;
        if (mpu_req_in.rd) begin
            case (mpu_req_in.addr)
                OFF_COUNT_LOW: next_rdata = view_sel_in ? fifo_cnt : count[7:0];
                OFF_COUNT_MID: next_rdata = view_sel_in ? {1'b0, host_cnt} : count[15:8];
                OFF_COUNT_HIGH: next_rdata = view_sel_in ? {6'h00, part_cnt} : count[23:16];
                OFF_ADDR_BYTE0: next_rdata = view_sel_in ? {1'b0, wr_ptr} : addr[7:0];
                OFF_ADDR_BYTE1: next_rdata = view_sel_in ? {1'b0, rd_ptr} : addr[15:8];
                OFF_ADDR_BYTE2: next_rdata = addr[23:16];
                OFF_ADDR_BYTE3: next_rdata = addr[31:24];
                OFF_BUFFER: next_rdata = buf_data;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fifo_cnt <= '0;
            host_cnt <= '0;
            part_cnt <= '0;
            buf_full <= 1'b0;
            mpu_rdata_out <= RDATA_RESET;
        end else begin
            fifo_cnt <= next_fifo_cnt;
            host_cnt <= next_host_cnt;
            part_cnt <= next_part_cnt;
            buf_full <= next_buf_full;
            mpu_rdata_out <= next_rdata;
        end
    end

    // ****************************************************************
    // Data FIFO
    // ****************************************************************
    xfer_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .PTR_W(FIFO_PTR_W)) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(fw_reset_in),
        .in_valid_in(push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(host_data_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(!buf_full),
        .out_data_out(fifo_out_data),
        .wr_load_in(wr_ptr_load),
        .rd_load_in(rd_ptr_load),
        .load_ptr_in(mpu_req_in.wdata[FIFO_PTR_W-1:0]),
        .wr_ptr_out(wr_ptr),
        .rd_ptr_out(rd_ptr)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_count_kept;
        fw_reset_in && !push && !cnt_wr |=> count == $past(count);
    endproperty
    a_count_kept: assert property (p_count_kept) else $error("count moved on firmware reset");
    property p_fw_clear;
        fw_reset_in |=> fifo_cnt == '0 && host_cnt == '0 && part_cnt == '0;
    endproperty
    a_fw_clear: assert property (p_fw_clear) else $error("counters not cleared");
    property p_count_read;
        mpu_req_in.rd && !view_sel_in && mpu_req_in.addr == OFF_COUNT_LOW |=> mpu_rdata_out == $past(count[7:0]);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count low byte read wrong");
    property p_count_dec;
        push && !cnt_wr |=> count == $past(count) - 24'h1;
    endproperty
    a_count_dec: assert property (p_count_dec) else $error("count not decremented");
    property p_force_full;
        fifo_cnt[FORCE_FULL_BIT] |-> !push && (state != ST_IDLE || next_state == ST_IDLE);
    endproperty
    a_force_full: assert property (p_force_full) else $error("fill while forced full");
    property p_diag_read;
        mpu_req_in.rd && view_sel_in && mpu_req_in.addr == OFF_COUNT_LOW |=> mpu_rdata_out == $past(fifo_cnt);
    endproperty
    a_diag_read: assert property (p_diag_read) else $error("fifo counter read wrong");
    property p_ptr_clear;
        fw_reset_in |=> wr_ptr == '0 && rd_ptr == '0;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("pointers not cleared");
    property p_upper;
        !wide_bus |-> host_addr_out[31:24] == 8'h00 && preempt_count_out == addr[31:24];
    endproperty
    a_upper: assert property (p_upper) else $error("top byte routed wrong");
    property p_addr_inc;
        beat && wide_bus && !addr_wr |=> addr == $past(addr) + $past(inc);
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address step wrong");
    property p_buf_kept;
        fw_reset_in && !buf_load && !wr_at |=> buf_data == $past(buf_data);
    endproperty
    a_buf_kept: assert property (p_buf_kept) else $error("buffer lost on reset");
    property p_view_neutral;
        $changed(view_sel_in) && !wr_at && !beat && !preempt_tick |=> addr == $past(addr) && count == $past(count);
    endproperty
    a_view_neutral: assert property (p_view_neutral) else $error("view change altered state");

    c_beat: cover property (beat ##[1:20] buf_full);
    c_force_full: cover property (fifo_cnt[FORCE_FULL_BIT] && count != '0);
    c_ptr_load: cover property (wr_ptr_load ##1 fifo_out_valid);
endmodule
`default_nettype wire

// [host_model.sv]
// Host bus model that answers each engine request with an acknowledge.
// Assumes the engine holds its request until it has seen the acknowledge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk_in,
    // Engine side
    input wire logic en_in,
    input wire logic req_in,
    output logic ack_out,
    output logic [7:0] data_out
);
    int n;
    initial begin
        n = 0;
        ack_out = 1'b0;
        data_out = 8'h5f;
        forever begin
            @(posedge clk_in iff (req_in && en_in));
            repeat (2) @(posedge clk_in);
            #1;
            data_out = 8'ha0 + 8'(n);
            ack_out = 1'b1;
            @(posedge clk_in iff !req_in);
            #1;
            ack_out = 1'b0;
            // Released data must not keep showing the last byte.
            data_out = ~data_out;
            n++;
        end
    end
endmodule
`default_nettype wire

// [xfer_regs_tb.sv]
// Self-checking bench for the transfer count and host address register group.
// Assumes the host model in host_model.sv and the design files compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module xfer_regs_tb;
    import xfer_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic fw_reset = 1'b0;
    logic view = 1'b0;
    logic [1:0] bus = 2'h3;
    logic [1:0] size = 2'h3;
    logic own;
    logic preempt = 1'b0;
    logic en = 1'b0;
    logic ack;
    logic req_out;
    logic rdy;
    logic [7:0] hdata;
    logic [7:0] rdata;
    logic [7:0] pcount;
    logic [31:0] haddr;
    mpu_req_t req = '0;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [12:0] rows [8] = '{{5'h18, 8'h12}, {5'h19, 8'h34}, {5'h1a, 8'h56}, {5'h1b, 8'h78},
                              {5'h1c, 8'h9a}, {5'h1d, 8'hbc}, {5'h1e, 8'hde}, {5'h1f, 8'h3c}};

    xfer_regs i_xfer_regs (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .fw_reset_in(fw_reset),
        .view_sel_in(view), .bus_type_in(bus), .mpu_req_in(req), .mpu_rdata_out(rdata),
        .fifo_rdy_out(rdy), .host_ack_pin_in(ack), .preempt_pin_in(preempt), .host_size_in(size),
        .host_data_in(hdata), .host_req_out(req_out), .host_own_out(own), .host_addr_out(haddr),
        .preempt_count_out(pcount));
    host_model i_host_model (.clk_in(sys_clk_in), .en_in(en), .req_in(req_out), .ack_out(ack),
        .data_out(hdata));

    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ****************************************************************
    // Register access tasks
    // ****************************************************************
    task automatic acc(input logic [4:0] a, input logic w, input logic [7:0] d);
        req = {a, w, !w, d};
        @(negedge sys_clk_in);
        req = '0;
        @(negedge sys_clk_in);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        acc(a, 1'b0, 8'h00);
        `CHK(rdata, e)
    endtask
    task automatic fw_pulse();
        fw_reset = 1'b1;
        @(negedge sys_clk_in);
        fw_reset = 1'b0;
    endtask
    task automatic wait_rdy();
        for (int i = 0; i < 100 && rdy !== 1'b1; i++) @(negedge sys_clk_in);
        `CHK(rdy, 1'b1)
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        foreach (rows[i]) begin
            acc(rows[i][12:8], 1'b1, rows[i][7:0]);
            rd(rows[i][12:8], rows[i][7:0]);
        end
        `CHK(haddr, 32'hdebc9a78)
        fw_pulse();
        rd(5'h18, 8'h12);
        rd(5'h1b, 8'h78);
        view = 1'b1;
        acc(5'h19, 1'b1, 8'h05);
        rd(5'h19, 8'h05);
        acc(5'h1b, 1'b1, 8'h03);
        rd(5'h1b, 8'h03);
        acc(5'h1f, 1'b1, 8'h69);
        fw_pulse();
        rd(5'h19, 8'h00);
        rd(5'h1b, 8'h00);
        rd(5'h1f, 8'h69);
        view = 1'b0;
        rd(5'h1b, 8'h78);
        rd(5'h10, 8'h00);
        foreach (rows[i]) acc(rows[i][12:8], 1'b1, i < 3 ? (i == 0 ? 8'h02 : 8'h00) : (i == 6 ? 8'h10 : 8'h00));
        en = 1'b1;
        wait_rdy();
        rd(5'h1f, 8'ha0);
        wait_rdy();
        rd(5'h1f, 8'ha1);
        rd(5'h18, 8'h00);
        rd(5'h1b, 8'h08);
        size = 2'h1;
        acc(5'h18, 1'b1, 8'h01);
        wait_rdy();
        rd(5'h1f, 8'ha2);
        rd(5'h1b, 8'h09);
        rd(5'h1b, 8'h09);
        view = 1'b1;
        rd(5'h18, 8'h00);
        rd(5'h19, 8'h03);
        rd(5'h1a, 8'h01);
        view = 1'b0;
        `CHK(own, 1'b0)
        `CHK(req_out, 1'b0)
        bus = 2'h0;
        preempt = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        preempt = 1'b0;
        repeat (8) @(negedge sys_clk_in);
        `CHK(pcount, 8'h11)
        `CHK(haddr[31:24], 8'h00)
        `CHK(own, 1'b1)
        en = 1'b0;
        acc(5'h1a, 1'b1, 8'h7e);
        rst_n_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        rd(5'h1a, 8'h7e);
        rd(5'h1e, 8'h11);
        rd(5'h1f, 8'ha2);
        view = 1'b1;
        rd(5'h19, 8'h00);
        rd(5'h1b, 8'h00);
        view = 1'b0;
        end_of_test();
    end
endmodule
`default_nettype wire
